// File: hw/dtc_ctrl.sv
// ddr4 command timing controller: reset exit, zq, self refresh and mpsm waits
// Contract
// [RQ1] device drives strobe from read latency minus one
// [RQ2] device releases strobe at latency plus half burst
// [RQ3] allow 1024 clocks for initial zq calibration
// [RQ4] wait 512 clocks after full zq calibration
// [RQ5] wait 128 clocks after short zq calibration
// [RQ6] reset exit wait max 5 clocks, trfc+10ns
// [RQ7] self refresh exit: trfc+10ns before non-dll commands
// [RQ8] abort exit: trfc4+10ns before non-dll commands
// [RQ9] zq and fast mode writes after trfc4+10ns
// [RQ10] device disables commands after tmod+cpded on mpsm
// [RQ11] keep clock valid tmod+cpded after mpsm entry
// [RQ12] valid clock before mpsm exit for cksrx
// [RQ13] after mpsm exit wait self refresh exit delay
// [RQ14] dll commands wait mpsm exit plus dll lock
// [RQ15] command pass disable delay equals four clocks
// [RQ16] stable clock max 5 clocks,10ns before exits
// [RQ17] ns minimums rounded up, enforced by down-counters
// [RQ18] refresh, mode update and dll lock are parameters
`timescale 1ns/10ps
module dtc_ctrl #(
   parameter int RFC_NS = 350,
   parameter int RFC4_NS = 160,
   parameter int MOD_NCK = 24,
   parameter int DLLK_NCK = 768,
   parameter int RL_NCK = 15
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CMD_VALID,
   input wire dtc_pkg::dtc_op_t CMD_OP,
   output logic CMD_READY,
   output logic DDR_CK,
   output logic DDR_RESET_N,
   output logic DDR_CKE,
   output logic DDR_CMD_VALID,
   output dtc_pkg::dtc_op_t DDR_CMD,
   output logic DQS_EXPECT,
   output logic IN_SREF,
   output logic IN_MPSM
);
   import dtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // derived wait counts in ck periods
   localparam int XS_NCK = ns_to_nck(RFC_NS + EXIT_EXTRA_NS); // RQ7 RQ17 RQ18
   localparam int XS4_NCK = ns_to_nck(RFC4_NS + EXIT_EXTRA_NS); // RQ8 RQ9 RQ17
   localparam int XPR_NCK = max_int(XPR_MIN_NCK, XS_NCK); // RQ6
   localparam int CKSRX_NCK = max_int(CKSRX_MIN_NCK, ns_to_nck(CKSRX_NS)); // RQ16
   localparam int MPE_NCK = MOD_NCK + CPDED_NCK; // RQ10 RQ11 RQ15
   localparam int XMP_NCK = XS_NCK; // RQ13
   localparam int XMPDLL_NCK = XMP_NCK + DLLK_NCK; // RQ14
   localparam int RD_ON = RL_NCK - 1;
   localparam int RD_OFF = RL_NCK + BURST_LEN / 2;

   dtc_tmr_if tif ();
   dtc_timer u_timer (.clk(CLK), .rst(SYS_RST), .tif(tif));

   dtc_state_t state_reg, state_next;
   logic ck_reg, ck_next;
   logic ck_run_reg, ck_run_next;
   logic reset_n_reg, reset_n_next;
   logic cke_reg, cke_next;
   logic cmd_v_reg, cmd_v_next;
   dtc_op_t cmd_reg, cmd_next;
   logic [TMR_W-1:0] wait_reg, wait_next;
   logic zq_init_reg, zq_init_next;
   logic rd_act_reg, rd_act_next;
   logic [RD_W-1:0] rd_cnt_reg, rd_cnt_next;
   logic dqs_reg, dqs_next;
   logic tick;
   logic class_ok;
   logic accept;

   ////////////////////////////////////////////////////////////////////////////////
   // command admission per class
   assign tick = ck_reg;
   assign tif.tick = tick;

   always_comb begin
      unique case (CMD_OP)
         OP_READ, OP_WRITE: class_ok = !tif.busy[TMR_DLL] && !tif.busy[TMR_NODLL]; // RQ14
         OP_MRS_FAST, OP_ZQ_LONG, OP_ZQ_SHORT: class_ok = !tif.busy[TMR_FAST]; // RQ9
         default: class_ok = !tif.busy[TMR_NODLL]; // RQ7 RQ8 RQ13
      endcase
   end

   always_comb begin
      CMD_READY = 1'b0;
      unique case (state_reg)
         ST_IDLE: CMD_READY = tick && class_ok && CMD_OP != OP_SR_EXIT
            && CMD_OP != OP_SR_ABORT_EXIT && CMD_OP != OP_MP_EXIT;
         ST_SREF: CMD_READY = tick && wait_reg == '0
            && (CMD_OP == OP_SR_EXIT || CMD_OP == OP_SR_ABORT_EXIT); // RQ16
         ST_MPSM: CMD_READY = (CMD_OP == OP_MP_EXIT);
         default: CMD_READY = 1'b0;
      endcase
   end
   assign accept = CMD_READY && CMD_VALID;

   ////////////////////////////////////////////////////////////////////////////////
   // main sequencer
   always_comb begin
      state_next = state_reg;
      ck_run_next = ck_run_reg;
      reset_n_next = reset_n_reg;
      cke_next = cke_reg;
      cmd_v_next = cmd_v_reg;
      cmd_next = cmd_reg;
      wait_next = wait_reg;
      zq_init_next = zq_init_reg;
      tif.load = '0;
      for (int k = 0; k < TMR_N; k++) begin
         tif.value[k] = '0;
      end
      if (tick) begin
         cmd_v_next = 1'b0;
         cmd_next = OP_NOP;
         if (wait_reg != '0) begin
            wait_next = wait_reg - TMR_W'(1);
         end
      end
      ck_next = ck_run_reg ? ~ck_reg : 1'b0;
      unique case (state_reg)
         ST_RST_HOLD: begin
            if (tick && wait_reg == '0) begin
               reset_n_next = 1'b1;
               wait_next = TMR_W'(CKSRX_NCK); // RQ16
               state_next = ST_CK_STABLE;
            end
         end
         ST_CK_STABLE: begin
            if (tick && wait_reg == '0) begin
               cke_next = 1'b1;
               tif.load = '1;
               for (int k = 0; k < TMR_N; k++) begin
                  tif.value[k] = TMR_W'(XPR_NCK); // RQ6
               end
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (accept) begin
               cmd_v_next = 1'b1;
               cmd_next = CMD_OP;
               unique case (CMD_OP)
                  OP_ZQ_LONG: begin
                     tif.load = '1;
                     for (int k = 0; k < TMR_N; k++) begin
                        tif.value[k] = zq_init_reg ? TMR_W'(ZQ_INIT_NCK) // RQ3
                           : TMR_W'(ZQ_OPER_NCK); // RQ4
                     end
                     zq_init_next = 1'b0;
                  end
                  OP_ZQ_SHORT: begin
                     tif.load = '1;
                     for (int k = 0; k < TMR_N; k++) begin
                        tif.value[k] = TMR_W'(ZQ_SHORT_NCK); // RQ5
                     end
                  end
                  OP_SR_ENTER: begin
                     cke_next = 1'b0;
                     wait_next = TMR_W'(CKSRX_NCK); // RQ16
                     state_next = ST_SREF;
                  end
                  OP_MP_ENTER: begin
                     wait_next = TMR_W'(MPE_NCK); // RQ11
                     state_next = ST_MP_HOLD;
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_SREF: begin
            if (accept) begin
               cke_next = 1'b1;
               cmd_v_next = 1'b1;
               cmd_next = CMD_OP;
               tif.load = '1;
               tif.value[TMR_NODLL] = (CMD_OP == OP_SR_ABORT_EXIT) ? TMR_W'(XS4_NCK) // RQ8
                  : TMR_W'(XS_NCK); // RQ7
               tif.value[TMR_DLL] = TMR_W'(DLLK_NCK);
               tif.value[TMR_FAST] = TMR_W'(XS4_NCK); // RQ9
               state_next = ST_IDLE;
            end
         end
         ST_MP_HOLD: begin
            if (tick && wait_reg == '0) begin
               cke_next = 1'b0;
               ck_run_next = 1'b0; // RQ11
               state_next = ST_MPSM;
            end
         end
         ST_MPSM: begin
            if (accept) begin
               ck_run_next = 1'b1;
               wait_next = TMR_W'(CKSRX_NCK); // RQ12
               state_next = ST_MP_CKUP;
            end
         end
         ST_MP_CKUP: begin
            if (tick && wait_reg == '0) begin
               cke_next = 1'b1;
               cmd_v_next = 1'b1;
               cmd_next = OP_MP_EXIT;
               tif.load = '1;
               tif.value[TMR_NODLL] = TMR_W'(XMP_NCK); // RQ13
               tif.value[TMR_DLL] = TMR_W'(XMPDLL_NCK); // RQ14
               tif.value[TMR_FAST] = TMR_W'(XMP_NCK);
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // expected strobe window of a read
   always_comb begin
      rd_act_next = rd_act_reg;
      rd_cnt_next = rd_cnt_reg;
      if (accept && CMD_OP == OP_READ) begin
         rd_act_next = 1'b1;
         rd_cnt_next = RD_W'(1);
      end else if (tick && rd_act_reg) begin
         rd_cnt_next = rd_cnt_reg + RD_W'(1);
         if (rd_cnt_reg >= RD_W'(RD_OFF)) begin
            rd_act_next = 1'b0;
         end
      end
      dqs_next = rd_act_next && rd_cnt_next >= RD_W'(RD_ON) // RQ1
         && rd_cnt_next < RD_W'(RD_OFF); // RQ2
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_reg <= ST_RST_HOLD;
         ck_reg <= 1'b0;
         ck_run_reg <= 1'b1;
         reset_n_reg <= 1'b0;
         cke_reg <= 1'b0;
         cmd_v_reg <= 1'b0;
         cmd_reg <= OP_NOP;
         wait_reg <= TMR_W'(RST_HOLD_NCK);
         zq_init_reg <= 1'b1;
         rd_act_reg <= 1'b0;
         rd_cnt_reg <= '0;
         dqs_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ck_reg <= ck_next;
         ck_run_reg <= ck_run_next;
         reset_n_reg <= reset_n_next;
         cke_reg <= cke_next;
         cmd_v_reg <= cmd_v_next;
         cmd_reg <= cmd_next;
         wait_reg <= wait_next;
         zq_init_reg <= zq_init_next;
         rd_act_reg <= rd_act_next;
         rd_cnt_reg <= rd_cnt_next;
         dqs_reg <= dqs_next;
      end
   end

   assign DDR_CK = ck_reg;
   assign DDR_RESET_N = reset_n_reg;
   assign DDR_CKE = cke_reg;
   assign DDR_CMD_VALID = cmd_v_reg;
   assign DDR_CMD = cmd_reg;
   assign DQS_EXPECT = dqs_reg;
   assign IN_SREF = (state_reg == ST_SREF);
   assign IN_MPSM = (state_reg == ST_MPSM);
endmodule : dtc_ctrl

// File: hw/dtc_timer.sv
// down-counting wait timers, one per command class
`timescale 1ns/10ps
module dtc_timer (
   input wire logic clk,
   input wire logic rst,
   dtc_tmr_if.tmr tif
);
   import dtc_pkg::*;

   genvar i;
   generate
      for (i = 0; i < TMR_N; i++) begin : g_tmr
         logic [TMR_W-1:0] cnt_reg;
         logic [TMR_W-1:0] cnt_next;
         // a new load only lengthens the wait, never shortens it
         always_comb begin
            cnt_next = cnt_reg;
            if (tif.tick && cnt_reg != '0) begin
               cnt_next = cnt_reg - TMR_W'(1);
            end
            if (tif.load[i] && tif.value[i] > cnt_next) begin
               cnt_next = tif.value[i];
            end
         end
         always_ff @(posedge clk) begin
            if (rst) begin
               cnt_reg <= '0;
            end else begin
               cnt_reg <= cnt_next;
            end
         end
         assign tif.busy[i] = (cnt_reg != '0);
      end
   endgenerate
endmodule : dtc_timer

// File: pkg/dtc_pkg.sv
// constants, command codes and states of the ddr4 timing controller
package dtc_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CK_PERIOD_NS = 2 * CLK_PERIOD_NS;
   localparam int ZQ_INIT_NCK = 1024;
   localparam int ZQ_OPER_NCK = 512;
   localparam int ZQ_SHORT_NCK = 128;
   localparam int CPDED_NCK = 4;
   localparam int CKSRX_MIN_NCK = 5;
   localparam int CKSRX_NS = 10;
   localparam int XPR_MIN_NCK = 5;
   localparam int EXIT_EXTRA_NS = 10;
   localparam int BURST_LEN = 8;
   localparam int RST_HOLD_NCK = 16;
   localparam int TMR_W = 16;
   localparam int TMR_N = 3;
   localparam int TMR_NODLL = 0;
   localparam int TMR_DLL = 1;
   localparam int TMR_FAST = 2;
   localparam int RD_W = 8;

   typedef enum logic [3:0] {
      OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_MRS, OP_MRS_FAST, OP_ZQ_LONG, OP_ZQ_SHORT,
      OP_SR_ENTER, OP_SR_EXIT, OP_SR_ABORT_EXIT, OP_MP_ENTER, OP_MP_EXIT
   } dtc_op_t;

   typedef enum logic [2:0] {
      ST_RST_HOLD, ST_CK_STABLE, ST_IDLE, ST_SREF, ST_MP_HOLD, ST_MPSM, ST_MP_CKUP
   } dtc_state_t;

   // ns figure to whole ck periods, rounded up, never below one
   function automatic int ns_to_nck(input int ns);
      int n;
      n = (ns + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
      return (n < 1) ? 1 : n;
   endfunction : ns_to_nck

   function automatic int max_int(input int a, input int b);
      return (a > b) ? a : b;
   endfunction : max_int
endpackage : dtc_pkg

// File: pkg/dtc_tmr_if.sv
// carrier between the controller and its wait timers
`timescale 1ns/10ps
interface dtc_tmr_if;
   logic tick;
   logic [dtc_pkg::TMR_N-1:0] load;
   logic [dtc_pkg::TMR_W-1:0] value [dtc_pkg::TMR_N];
   logic [dtc_pkg::TMR_N-1:0] busy;
   modport ctrl (output tick, output load, output value, input busy);
   modport tmr (input tick, input load, input value, output busy);
endinterface : dtc_tmr_if

// File: testbench/dtc_ctrl_test.sv
// self-checking bench for the ddr4 timing controller
`timescale 1ns/10ps
module dtc_ctrl_test;
   import dtc_pkg::*;
   localparam int RFC = 350;
   localparam int DLLK = 8;
   logic clk = 0, sys_rst = 1, cmd_valid = 0, cmd_ready, ddr_ck, ddr_reset_n, ddr_cke;
   logic ddr_cmd_valid, dqs_expect, in_sref, in_mpsm, dqs_oe_n;
   dtc_op_t cmd_op = OP_NOP, ddr_cmd;
   dtc_op_t tbl [8][3];
   dtc_op_t rnd_ops [6] = '{OP_ACT, OP_WRITE, OP_READ, OP_MRS, OP_MRS_FAST, OP_ZQ_SHORT};
   int err_total = 0, tests_run = 0, bad_cnt, cyc = 0, t_take, t0, ta, n_exp, n_drv, xs, xs4;
   int lo [8];
   logic [31:0] rng = 32'HD7E8;
   dtc_ctrl #(.RFC_NS(RFC), .DLLK_NCK(DLLK)) uut (.CLK(clk), .SYS_RST(sys_rst),
      .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_READY(cmd_ready), .DDR_CK(ddr_ck),
      .DDR_RESET_N(ddr_reset_n), .DDR_CKE(ddr_cke), .DDR_CMD_VALID(ddr_cmd_valid),
      .DDR_CMD(ddr_cmd), .DQS_EXPECT(dqs_expect), .IN_SREF(in_sref), .IN_MPSM(in_mpsm));
   dtc_dram_model u_dram (.ddr_ck(ddr_ck), .ddr_reset_n(ddr_reset_n),
      .ddr_cmd_valid(ddr_cmd_valid), .ddr_cmd(ddr_cmd), .dqs_oe_n(dqs_oe_n), .bad_cnt(bad_cnt));
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////
   function automatic int ck_clk(input int ns);
      return 2 * ((ns + CK_PERIOD_NS - 1) / CK_PERIOD_NS);
   endfunction : ck_clk
   function automatic logic [31:0] xs32(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs32
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'H1) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask : check
   task automatic issue(input dtc_op_t op);
      int n;
      n = 0;
      @(negedge clk);
      cmd_valid = 1'H1;
      cmd_op = op;
      #1;
      while (cmd_ready !== 1'H1 && n < 4000) begin
         @(negedge clk);
         #1;
         n++;
      end
      if (n >= 4000) begin
         err_total++;
         $display("CHECK FAILED t=%0t command never taken", $time);
      end
      @(posedge clk);
      t_take = cyc;
      @(negedge clk);
      cmd_valid = 1'H0;
   endtask : issue
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////
   initial begin
      #(1000000);
      err_total++;
      complete_run();
   end
   initial begin
      xs = ck_clk(RFC + EXIT_EXTRA_NS);
      xs4 = ck_clk(160 + EXIT_EXTRA_NS);
      tbl = '{'{OP_ACT, OP_ZQ_LONG, OP_ACT}, '{OP_ACT, OP_ZQ_LONG, OP_ACT},
         '{OP_ACT, OP_ZQ_SHORT, OP_ACT}, '{OP_SR_ENTER, OP_SR_EXIT, OP_ACT},
         '{OP_SR_ENTER, OP_SR_ABORT_EXIT, OP_ACT}, '{OP_SR_ENTER, OP_SR_EXIT, OP_ZQ_SHORT},
         '{OP_MP_ENTER, OP_MP_EXIT, OP_ACT}, '{OP_MP_ENTER, OP_MP_EXIT, OP_READ}};
      lo = '{2 * ZQ_INIT_NCK, 2 * ZQ_OPER_NCK, 2 * ZQ_SHORT_NCK, xs, xs4, xs4,
         2 * (CKSRX_MIN_NCK + 1) + xs, 2 * (CKSRX_MIN_NCK + 1 + DLLK) + xs};
      repeat (20) @(negedge clk);
      check(ddr_reset_n === 1'H0 && ddr_cke === 1'H0 && cmd_ready === 1'H0, "reset outputs");
      sys_rst = 1'H0;
      t0 = cyc;
      issue(OP_ACT);
      check(t_take - t0 >= 2 * (RST_HOLD_NCK + CKSRX_MIN_NCK) + xs, "reset exit early");
      for (int i = 0; i < 8; i++) begin
         issue(tbl[i][0]);
         ta = t_take;
         issue(tbl[i][1]);
         t0 = t_take;
         if (i >= 6) check(t0 - ta >= 2 * (24 + CPDED_NCK), "mpsm entered early");
         issue(tbl[i][2]);
         check(t_take - t0 >= lo[i] && t_take - t0 <= lo[i] + 6, "command wait wrong");
      end
      n_exp = 0;
      n_drv = 0;
      repeat (80) begin
         @(negedge clk);
         n_exp += int'(dqs_expect === 1'H1);
         n_drv += int'(dqs_oe_n === 1'H0);
      end
      check(n_exp == 2 * (BURST_LEN / 2 + 1) && n_drv == n_exp, "strobe window length");
      repeat (30) begin
         rng = xs32(rng);
         issue(rnd_ops[rng % 6]);
         repeat (rng[9:8]) @(negedge clk);
      end
      check(bad_cnt == 0, "command during mpsm");
      complete_run();
   end
endmodule : dtc_ctrl_test

// File: testbench/dtc_dram_model.sv
// behavioural sdram model: read strobe window and mpsm command path
`timescale 1ns/10ps
module dtc_dram_model #(
   parameter int RL_NCK = 15,
   parameter int MOD_NCK = 24
) (
   input wire logic ddr_ck,
   input wire logic ddr_reset_n,
   input wire logic ddr_cmd_valid,
   input wire dtc_pkg::dtc_op_t ddr_cmd,
   output logic dqs_oe_n,
   output int bad_cnt
);
   import dtc_pkg::*;
   int rd_reg, rd_next, mp_reg, mp_next, bad_next;
   logic off_reg, off_next;
   always_comb begin
      rd_next = (rd_reg < 255) ? rd_reg + 1 : rd_reg;
      mp_next = (mp_reg > 0) ? mp_reg - 1 : 0;
      off_next = off_reg || mp_reg == 1;
      bad_next = bad_cnt;
      if (ddr_cmd_valid && ddr_cmd == OP_READ) begin
         rd_next = 1;
      end
      if (ddr_cmd_valid && ddr_cmd == OP_MP_ENTER) begin
         mp_next = MOD_NCK + CPDED_NCK;
      end
      if (ddr_cmd_valid && ddr_cmd == OP_MP_EXIT) begin
         off_next = 1'H0;
      end else if (ddr_cmd_valid && off_reg) begin
         bad_next = bad_cnt + 1;
      end
   end
   always_ff @(posedge ddr_ck or negedge ddr_reset_n) begin
      if (!ddr_reset_n) begin
         rd_reg <= 255;
         mp_reg <= 0;
         off_reg <= 1'H0;
         bad_cnt <= 0;
      end else begin
         rd_reg <= rd_next;
         mp_reg <= mp_next;
         off_reg <= off_next;
         bad_cnt <= bad_next;
      end
   end
   assign dqs_oe_n = !(rd_reg >= RL_NCK - 1 && rd_reg < RL_NCK + BURST_LEN / 2);
endmodule : dtc_dram_model

// File: testbench/dtc_properties.sv
// assertion checker bound to the ddr4 timing controller
`timescale 1ns/10ps
module dtc_properties #(
   parameter int RFC_NS = 350,
   parameter int RFC4_NS = 160,
   parameter int MOD_NCK = 24,
   parameter int DLLK_NCK = 768,
   parameter int RL_NCK = 15
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic DDR_CK,
   input wire logic DDR_CKE,
   input wire logic DDR_CMD_VALID,
   input wire dtc_pkg::dtc_op_t DDR_CMD,
   input wire logic DQS_EXPECT
);
   import dtc_pkg::*;
   localparam int XS = 2 * ((RFC_NS + EXIT_EXTRA_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS);
   localparam int XS4 = 2 * ((RFC4_NS + EXIT_EXTRA_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS);
   localparam int DQ_ON = 2 * RL_NCK - 4;
   localparam int MP_HOLD = 2 * (MOD_NCK + CPDED_NCK) - 2;
   logic v_reg, v_next, ck_reg, ck_next, new_cmd;
   int gap_reg, gap_next, run_reg, run_next, zq_reg, zq_next;
   dtc_op_t last_reg, last_next;
   ////////////////////////////////////////////////////////////
   always_comb begin
      new_cmd = DDR_CMD_VALID && (!v_reg || gap_reg == 1);
      v_next = DDR_CMD_VALID;
      ck_next = DDR_CK;
      gap_next = new_cmd ? 0 : gap_reg + 1;
      last_next = new_cmd ? DDR_CMD : last_reg;
      zq_next = (new_cmd && DDR_CMD == OP_ZQ_LONG) ? zq_reg + 1 : zq_reg;
      run_next = (DDR_CK != ck_reg) ? run_reg + 1 : 0;
   end
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         v_reg <= 1'H0;
         ck_reg <= 1'H0;
         gap_reg <= 0;
         run_reg <= 0;
         zq_reg <= 0;
         last_reg <= OP_NOP;
      end else begin
         v_reg <= v_next;
         ck_reg <= ck_next;
         gap_reg <= gap_next;
         run_reg <= run_next;
         zq_reg <= zq_next;
         last_reg <= last_next;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_after(dtc_op_t op); new_cmd && last_reg == op; endsequence
   sequence s_cke_drop; ##MP_HOLD DDR_CKE ##[1:8] !DDR_CKE; endsequence
   property p_zq_long;
      s_after(OP_ZQ_LONG) |-> gap_reg + 1 >= 2 * ((zq_reg == 1) ? ZQ_INIT_NCK : ZQ_OPER_NCK);
   endproperty
   a_zq_long: assert property (p_zq_long) else $error("zq long wait short");
   property p_zq_short; s_after(OP_ZQ_SHORT) |-> gap_reg + 1 >= 2 * ZQ_SHORT_NCK; endproperty
   a_zq_short: assert property (p_zq_short) else $error("zq short wait short");
   property p_sr_exit;
      s_after(OP_SR_EXIT) ##0 !(DDR_CMD inside {OP_ZQ_LONG, OP_ZQ_SHORT, OP_MRS_FAST})
         |-> gap_reg + 1 >= XS;
   endproperty
   a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit wait short");
   property p_fast; new_cmd && last_reg inside {OP_SR_EXIT, OP_SR_ABORT_EXIT} |-> gap_reg >= XS4 - 1;
   endproperty
   a_fast: assert property (p_fast) else $error("fast exit wait short");
   property p_mp_exit; s_after(OP_MP_EXIT) |-> gap_reg + 1 >= XS; endproperty
   a_mp_exit: assert property (p_mp_exit) else $error("mpsm exit wait short");
   property p_mp_dll;
      s_after(OP_MP_EXIT) ##0 DDR_CMD inside {OP_READ, OP_WRITE} |-> gap_reg + 1 >= XS + 2 * DLLK_NCK;
   endproperty
   a_mp_dll: assert property (p_mp_dll) else $error("mpsm dll wait short");
   property p_mp_hold; new_cmd && DDR_CMD == OP_MP_ENTER |-> s_cke_drop; endproperty
   a_mp_hold: assert property (p_mp_hold) else $error("mpsm clock hold wrong");
   property p_ck_run; $rose(DDR_CKE) |-> run_reg >= 2 * CKSRX_MIN_NCK - 2; endproperty
   a_ck_run: assert property (p_ck_run) else $error("clock not stable before cke");
   property p_dqs; new_cmd && DDR_CMD == OP_READ |-> ##DQ_ON DQS_EXPECT [*8]; endproperty
   a_dqs: assert property (p_dqs) else $error("strobe window wrong");
endmodule : dtc_properties

bind dtc_ctrl dtc_properties #(.RFC_NS(RFC_NS), .RFC4_NS(RFC4_NS), .MOD_NCK(MOD_NCK),
   .DLLK_NCK(DLLK_NCK), .RL_NCK(RL_NCK)) u_props (.CLK(CLK), .SYS_RST(SYS_RST),
   .DDR_CK(DDR_CK), .DDR_CKE(DDR_CKE), .DDR_CMD_VALID(DDR_CMD_VALID), .DDR_CMD(DDR_CMD),
   .DQS_EXPECT(DQS_EXPECT));
